/* File: rtl/oce_map.vh */
// constants for the output clock edge control block
// assumes a 20 MHz mclk and a 26-step phase grid per sample period
`ifndef OCE_MAP_VH
`define OCE_MAP_VH
`define OCE_REG_EDGE     8'h44
`define OCE_REG_IFSEL    8'h41
`define OCE_EDGE_RESET   8'h00
`define OCE_IFSEL_RESET  8'h00
`define OCE_IFSEL_BIT    7
`define OCE_UP_HI        7
`define OCE_UP_LO        5
`define OCE_LO_HI        4
`define OCE_LO_LO        2
`define OCE_CODE_DEF0    3'h0
`define OCE_CODE_DEF1    3'h4
`define OCE_CODE_DLY4    3'h5
`define OCE_CODE_ADV7    3'h6
`define OCE_CODE_ADV4    3'h7
`define OCE_STEPS        5'h1A
`define OCE_HALF         5'h0D
`define OCE_SHIFT4       5'h04
`define OCE_SHIFT7       5'h07
`define OCE_ZERO_PH      5'h00
`define OCE_STEPS_WIDE   10'h01A
`define OCE_RDATA_ZERO   8'h00
`endif

/* File: rtl/oce_phase_gen.v */
// 26-step phase counter locked to the sampled conversion clock
// assumes convClk was already passed through two flip-flops
`timescale 1ns/1ns
`include "oce_map.vh"
module oce_phase_gen (
  mclk,
  resetn,
  convClkSync,
  phase,
  periodStart
);
  input  wire       mclk;
  input  wire       resetn;
  input  wire       convClkSync;
  output reg  [4:0] phase;
  output wire       periodStart;

  reg convPrev_q;

  // each rising edge of the sample clock restarts the count; the count
  // holds at the last step, so a long period reads as 26 cycles and
  // never wraps into a false short length
  assign periodStart = convClkSync & ~convPrev_q;

  always @(posedge mclk) begin
    if (!resetn) begin
      convPrev_q <= 1'b0;
      phase      <= `OCE_ZERO_PH;
    end else begin
      convPrev_q <= convClkSync;
      if (periodStart)
        phase <= `OCE_ZERO_PH;
      else if (phase != `OCE_STEPS - 5'h01)
        phase <= phase + 5'h01;
    end
  end
endmodule // oce_phase_gen

/* File: rtl/oce_edge_ctrl.v */
// output clock edge placement for the converter output port
// assumes a simple register write/read port on mclk and an external
// conversion clock; phase resolution is limited by the mclk rate
// the 26-step grid is mapped onto the measured length of the last
// sample period, so a shift keeps its share of the period as the
// conversion rate changes; periods above 26 mclk cycles are capped
//
// What this block does
// - six-bit field in bits 7:2 places edges, meaning depends on interface.
// - codes 000 and 100 keep the edge at its default position.
// - falling edge: upper field in differential, lower in single-ended.
// - rising edge: lower field in differential, upper in single-ended.
// - every shift is a fraction of the sample period, tracking rate up to 26 mclk cycles.
// - interface bit zero means single-ended, one means differential.
`timescale 1ns/1ns
`include "oce_map.vh"
module oce_edge_ctrl (
  mclk,
  resetn,
  regWrite,
  regAddr,
  regWdata,
  regRdata,
  convClk,
  sampleOutputClock,
  ddrMode,
  risePhase,
  fallPhase
);
  input  wire       mclk;
  input  wire       resetn;
  input  wire       regWrite;
  input  wire [7:0] regAddr;
  input  wire [7:0] regWdata;
  output reg  [7:0] regRdata;
  input  wire       convClk;
  output reg        sampleOutputClock;
  output wire       ddrMode;
  output reg  [4:0] risePhase;
  output reg  [4:0] fallPhase;

  reg  [7:0] edgeCtrl_q;
  reg  [7:0] ifSel_q;
  reg        convMeta_q;
  reg        convSync_q;
  wire [4:0] phase;
  wire       periodStart;
  reg  [2:0] riseCode;
  reg  [2:0] fallCode;
  reg  [4:0] riseNext;
  reg  [4:0] fallNext;
  reg  [4:0] periodLen_q;
  wire [4:0] riseCycle;
  wire [4:0] fallCycle;

  // pick one three-bit subfield of the edge byte; used for both
  // edges, with the choice of half flipped by the interface bit
  function [2:0] pickField;
    input [7:0] ctrl;
    input       upper;
    begin
      if (upper)
        pickField = ctrl[`OCE_UP_HI:`OCE_UP_LO];
      else
        pickField = ctrl[`OCE_LO_HI:`OCE_LO_LO];
    end
  endfunction

  // turn a grid step (0..25 of 26) into an mclk cycle of the period
  // the product stays below 26 * 26, so ten bits never overflow;
  // the result is rounded down, which is the coarse part of the grid
  function [4:0] stepToCycle;
    input [4:0] step;
    input [4:0] len;
    reg   [9:0] prod;
    begin
      prod        = {5'h00, step} * {5'h00, len};
      prod        = prod / `OCE_STEPS_WIDE;
      stepToCycle = prod[4:0];
    end
  endfunction

  // map a code to a target phase around a default edge phase
  // advances are added as 26 minus the shift so the sum never goes
  // negative; one conditional subtract brings it back onto the grid
  function [4:0] edgePos;
    input [2:0] code;
    input [4:0] base;
    reg   [5:0] sum;
    begin
      sum = {1'b0, base};
      case (code)
        `OCE_CODE_DLY4: sum = {1'b0, base} + {1'b0, `OCE_SHIFT4};
        `OCE_CODE_ADV7: sum = {1'b0, base} + {1'b0, `OCE_STEPS}
                              - {1'b0, `OCE_SHIFT7};
        `OCE_CODE_ADV4: sum = {1'b0, base} + {1'b0, `OCE_STEPS}
                              - {1'b0, `OCE_SHIFT4};
        default: sum = {1'b0, base};
      endcase
      if (sum >= {1'b0, `OCE_STEPS})
        sum = sum - {1'b0, `OCE_STEPS};
      edgePos = sum[4:0];
    end
  endfunction

  // registers: bits 1:0 stored as written, host keeps them zero
  always @(posedge mclk) begin
    if (!resetn) begin
      edgeCtrl_q <= `OCE_EDGE_RESET;
      ifSel_q    <= `OCE_IFSEL_RESET;
    end else if (regWrite) begin
      if (regAddr == `OCE_REG_EDGE)
        edgeCtrl_q <= regWdata;
      if (regAddr == `OCE_REG_IFSEL)
        ifSel_q <= regWdata;
    end
  end

  // read back; unmapped addresses read zero
  always @(posedge mclk) begin
    if (!resetn)
      regRdata <= 8'h00;
    else if (regAddr == `OCE_REG_EDGE)
      regRdata <= edgeCtrl_q;
    else if (regAddr == `OCE_REG_IFSEL)
      regRdata <= ifSel_q;
    else
      regRdata <= `OCE_RDATA_ZERO;
  end

  assign ddrMode = ifSel_q[`OCE_IFSEL_BIT];

  // subfield routing swaps with the interface choice
  // differential: upper half moves the fall; single-ended: the rise
  always @* begin
    fallCode = pickField(edgeCtrl_q, ddrMode);
    riseCode = pickField(edgeCtrl_q, ~ddrMode);
    riseNext = edgePos(riseCode, `OCE_ZERO_PH);
    fallNext = edgePos(fallCode, `OCE_HALF);
  end

  // two-flop synchroniser for the foreign conversion clock
  always @(posedge mclk) begin
    if (!resetn) begin
      convMeta_q <= 1'b0;
      convSync_q <= 1'b0;
    end else begin
      convMeta_q <= convClk;
      convSync_q <= convMeta_q;
    end
  end

  oce_phase_gen uPhase (
    .mclk        (mclk),
    .resetn      (resetn),
    .convClkSync (convSync_q),
    .phase       (phase),
    .periodStart (periodStart)
  );

  // length of the last sample period in mclk cycles; the phase count
  // holds at 25, so a slow conversion clock reads as 26 cycles and
  // its edges then sit on a fixed grid rather than a scaled one
  always @(posedge mclk) begin
    if (!resetn)
      periodLen_q <= `OCE_STEPS;
    else if (periodStart)
      periodLen_q <= phase + 5'h01;
  end

  // grid steps scaled onto the measured period
  assign riseCycle = stepToCycle(risePhase, periodLen_q);
  assign fallCycle = stepToCycle(fallPhase, periodLen_q);

  // edge targets load only at a period start so a rewrite never
  // produces a runt pulse mid-period
  always @(posedge mclk) begin
    if (!resetn) begin
      risePhase <= `OCE_ZERO_PH;
      fallPhase <= `OCE_HALF;
    end else if (periodStart) begin
      risePhase <= riseNext;
      fallPhase <= fallNext;
    end
  end

  // output clock toggles at the scaled cycles of the selected steps
  // latency: a conversion clock rise is seen three mclk later, so the
  // whole output clock trails the sample clock by that fixed amount
  // when both edges land on one cycle the rise wins and the clock
  // stays high; only short periods do that, and equal shift codes only at a one-cycle period
  always @(posedge mclk) begin
    if (!resetn)
      sampleOutputClock <= 1'b0;
    else if (phase == riseCycle)
      sampleOutputClock <= 1'b1;
    else if (phase == fallCycle)
      sampleOutputClock <= 1'b0;
  end
endmodule // oce_edge_ctrl

/* File: sim/oce_chk_sva.sv */
// port checker for the output clock edge block
// assumes binding onto oce_edge_ctrl, registers at 0x44 and 0x41
`timescale 1ns/1ns
module oce_chk (
  input wire       mclk,
  input wire       resetn,
  input wire       regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire       ddrMode,
  input wire [4:0] risePhase,
  input wire [4:0] fallPhase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // mode bit follows the write one cycle later
  chk_ddr_select: assert property (
    regWrite && regAddr == 8'h41 |=> ddrMode == $past(regWdata[7]))
    else $error("interface bit not stored");
  // the whole byte is read back, low bits included
  chk_reg_echo: assert property (
    regWrite && regAddr == 8'h44 ##1 !regWrite && regAddr == 8'h44
    |=> regRdata == $past(regWdata, 2)) else $error("edge byte lost");
  chk_phase_range: assert property (
    risePhase < 5'h1A && fallPhase < 5'h1A) else $error("off grid");
  chk_unmapped_zero: assert property (
    regAddr == 8'h45 |=> regRdata == 8'h00) else $error("bad read");
  chk_rise_grid: assert property (
    risePhase inside {5'h00, 5'h04, 5'h13, 5'h16})
    else $error("rise step not allowed");
  chk_fall_grid: assert property (
    fallPhase inside {5'h0D, 5'h11, 5'h06, 5'h09})
    else $error("fall step not allowed");
  cover property (regWrite && regAddr == 8'h41 && regWdata[7]);
  cover property (risePhase == 5'h04);
  cover property (fallPhase == 5'h06);
endmodule // oce_chk
bind oce_edge_ctrl oce_chk i_chk (.mclk(mclk), .resetn(resetn),
  .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .ddrMode(ddrMode), .risePhase(risePhase),
  .fallPhase(fallPhase));

/* File: sim/oce_capture.sv */
// sample clock source of the capture side
// free running, phase unrelated to mclk
`timescale 1ns/1ns
module oce_capture (
  output logic convClk
);
  // odd start offset keeps its edges away from mclk edges
  initial begin
    convClk = 1'b0;
    #37;
    forever #200 convClk = ~convClk;
  end
endmodule // oce_capture

/* File: sim/oce_edge_ctrl_tb_top.sv */
// register driven bench for the edge control block
// assumes oce_capture supplies the conversion clock
`timescale 1ns/1ns
module oce_edge_ctrl_tb_top;
  logic mclk = 1'b0, resetn, regWrite, convClk;
  logic [7:0] regAddr, regWdata;
  wire [7:0] regRdata;
  wire [4:0] risePhase, fallPhase;
  wire sampleOutputClock, ddrMode;
  int num_errors = 0, n_compared = 0, m, c, hi;
  logic [2:0] u, l;
  oce_edge_ctrl i_dut (.mclk(mclk), .resetn(resetn), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .convClk(convClk), .sampleOutputClock(sampleOutputClock),
    .ddrMode(ddrMode), .risePhase(risePhase), .fallPhase(fallPhase));
  oce_capture i_cap (.convClk(convClk));
  always #25 mclk = ~mclk;
  task cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) begin regWrite <= 1; regAddr <= a; regWdata <= d; end
    @(posedge mclk) regWrite <= 0;
  endtask
  // read data is one edge behind the address
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) regAddr <= a;
    repeat (2) @(posedge mclk);
    cmp(regRdata, e);
  endtask
  // grid step of an edge: shifts wrap around the 26-step period
  function automatic logic [7:0] sh(input logic [2:0] k, input int b);
    case (k)
      3'h5: b = (b + 4) % 26;
      3'h6: b = (b + 19) % 26;
      3'h7: b = (b + 22) % 26;
      default: ;
    endcase
    return 8'(b);
  endfunction
  // 400 ns sample period over a 50 ns mclk is 8 cycles per period
  function automatic int cy(input logic [7:0] s);
    return s * 8 / 26;
  endfunction
  task end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
  initial begin
    resetn = 0; regWrite = 0; regAddr = 8'h00; regWdata = 8'h00;
    repeat (5) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    cmp(fallPhase, 8'h0D);
    // unequal subfields expose which one moves which edge
    for (m = 0; m < 2; m++) for (c = 0; c < 8; c++) begin
      u = c[2:0];
      l = ~u;
      wr(8'h41, {m[0], 7'h00});
      wr(8'h44, {u, l, 2'b00});
      rd(8'h44, {u, l, 2'b00});
      repeat (20) @(posedge mclk);
      cmp({7'h00, ddrMode}, m[7:0]);
      cmp(risePhase, sh(m ? l : u, 0));
      cmp(fallPhase, sh(m ? u : l, 13));
      hi = 0;
      repeat (8) @(posedge mclk) hi += sampleOutputClock;
      cmp(8'(hi), 8'((cy(sh(m ? u : l, 13)) - cy(sh(m ? l : u, 0)) + 8) % 8));
    end
    wr(8'h44, 8'hB4);
    repeat (20) @(posedge mclk);
    hi = 0;
    repeat (8) @(posedge mclk) hi += sampleOutputClock;
    cmp(8'(hi), 8'h04);
    rd(8'h45, 8'h00);
    end_sim;
  end
endmodule // oce_edge_ctrl_tb_top
